// ===== rtl/printer_control_code_decoder.sv
// Printer control unit: takes characters from the host one at a time, decodes control codes and drives the printer.
// Assumes a host on the same clock using one-cycle strobes, and a printer whose done pin is asynchronous.
`timescale 1ns/100ps
`include "printer_ctl_consts.svh"

module printer_control_code_decoder
#(
  parameter int DATA_W = 8
)
(
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  input  wire logic              ce_in,
  input  wire logic [3:0]        addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [DATA_W-1:0] rdata_out,
  input  wire logic              printer_done_in,
  output logic                   act_valid_out,
  output logic      [3:0]        act_code_out,
  output logic      [5:0]        act_char_out,
  output logic                   ribbon_red_out,
  output logic                   unit_resp_out,
  output logic                   irq_out,
  output logic                   err_irq_out
);

  printer_ctl_pkg::state_e state_ff;
  printer_ctl_pkg::state_e nxt_state;
  logic [6:0]        output_char_buffer_ff;
  logic [6:0]        nxt_output_char_buffer;
  logic [7:0]        unit_addr_ff;
  logic [7:0]        nxt_unit_addr;
  logic [DATA_W-1:0] nxt_rdata;
  logic [3:0]        nxt_act_code;
  logic [5:0]        nxt_act_char;
  logic              nxt_act_valid;
  logic              nxt_ribbon_red;
  logic              nxt_unit_resp;
  logic              nxt_irq;
  logic              nxt_err_irq;
  logic              rm_ff;
  logic              nxt_rm;
  logic              ms_ff;
  logic              nxt_ms;
  logic              message_end_flag_ff;
  logic              nxt_message_end_flag;
  logic              alert_ff;
  logic              nxt_alert;
  logic              oerr_ff;
  logic              nxt_oerr;
  logic              pending_ff;
  logic              nxt_pending;
  logic              err_latched_ff;
  logic              nxt_err_latched;
  logic              retry_ff;
  logic              nxt_retry;
  logic              resp_status_ff;
  logic              nxt_resp_status;
  logic              done_meta_ff;
  logic              done_sync_ff;
  logic              done_prev_ff;
  logic              done_rise;
  logic              char_take;
  logic              par_ok;
  logic              is_flag;
  logic              is_rm;
  logic [3:0]        digit;
  logic              digit_ok;
  logic              exempt;
  logic [7:0]        status_word;

  char_checker u_check
  (
    .char_in         (wdata_in[6:0]),
    .parity_ok_out   (par_ok),
    .flag_out        (is_flag),
    .record_mark_out (is_rm),
    .digit_out       (digit),
    .valid_digit_out (digit_ok)
  );

  assign char_take = wr_in && (addr_in == `PCD_OFF_CHAR) && (state_ff == printer_ctl_pkg::ST_IDLE);
  assign done_rise = done_sync_ff && !done_prev_ff;
  // A leading record mark or a mode shift character passes a latched error.
  assign exempt    = (!pending_ff && is_rm) || (pending_ff && (digit == `PCD_FN_MODE));

  always_comb
  begin
    status_word                       = 8'h00;
    status_word[`PCD_ST_BUSY]         = (state_ff != printer_ctl_pkg::ST_IDLE);
    status_word[`PCD_ST_RM]           = rm_ff;
    status_word[`PCD_ST_MS]           = ms_ff;
    status_word[`PCD_ST_END]          = message_end_flag_ff;
    status_word[`PCD_ST_ALERT]        = alert_ff;
    status_word[`PCD_ST_OERR]         = oerr_ff;
    status_word[`PCD_ST_UNIT_RESP]    = unit_resp_out;
    status_word[`PCD_ST_RESP_STATUS]  = resp_status_ff;
  end

  always_comb
  begin
    nxt_state              = state_ff;
    nxt_output_char_buffer = output_char_buffer_ff;
    nxt_unit_addr          = unit_addr_ff;
    nxt_rdata              = '0;
    nxt_act_valid          = 1'b0;
    nxt_act_code           = act_code_out;
    nxt_act_char           = act_char_out;
    nxt_ribbon_red         = ribbon_red_out;
    nxt_unit_resp          = unit_resp_out;
    nxt_irq                = 1'b0;
    nxt_err_irq            = 1'b0;
    nxt_rm                 = rm_ff;
    nxt_ms                 = ms_ff;
    nxt_message_end_flag   = message_end_flag_ff;
    nxt_alert              = alert_ff;
    nxt_oerr               = oerr_ff;
    nxt_pending            = pending_ff;
    nxt_err_latched        = err_latched_ff;
    nxt_retry              = retry_ff;
    nxt_resp_status        = resp_status_ff;

    // Testing an indicator returns it in bit 0 and clears it.
    if (rd_in)
    begin
      if (addr_in == `PCD_OFF_CHAR)
      begin
        nxt_rdata[6:0] = output_char_buffer_ff;
      end
      else if (addr_in == `PCD_OFF_STATUS)
      begin
        nxt_rdata[7:0] = status_word;
      end
      else if (addr_in == `PCD_OFF_TEST_RM)
      begin
        nxt_rdata[0] = rm_ff;
        nxt_rm       = 1'b0;
      end
      else if (addr_in == `PCD_OFF_TEST_MS)
      begin
        nxt_rdata[0] = ms_ff;
        nxt_ms       = 1'b0;
      end
      else if (addr_in == `PCD_OFF_TEST_END)
      begin
        nxt_rdata[0]         = message_end_flag_ff;
        nxt_message_end_flag = 1'b0;
      end
      else if (addr_in == `PCD_OFF_TEST_ALERT)
      begin
        nxt_rdata[0] = alert_ff;
        nxt_alert    = 1'b0;
      end
      else if (addr_in == `PCD_OFF_TEST_OERR)
      begin
        nxt_rdata[0] = oerr_ff;
        nxt_oerr     = 1'b0;
        if (oerr_ff)
        begin
          nxt_err_latched = 1'b0;
          nxt_retry       = 1'b1;
        end
      end
      else if (addr_in == `PCD_OFF_UNIT_ADDR)
      begin
        nxt_rdata[7:0] = unit_addr_ff;
      end
      else
      begin
        nxt_rdata = '0;
      end
    end

    if (wr_in)
    begin
      if (addr_in == `PCD_OFF_CTRL)
      begin
        if (wdata_in[`PCD_CTRL_ACK])
        begin
          nxt_unit_resp = 1'b0;
        end
        if (wdata_in[`PCD_CTRL_RESPOND])
        begin
          nxt_resp_status = 1'b1;
        end
      end
      else if (addr_in == `PCD_OFF_UNIT_ADDR)
      begin
        // Only a pair of decimal digits is taken.
        if ((wdata_in[7:4] <= `PCD_MAX_DIGIT) && (wdata_in[3:0] <= `PCD_MAX_DIGIT))
        begin
          nxt_unit_addr = wdata_in[7:0];
        end
      end
    end

    if (char_take)
    begin
      nxt_unit_resp = 1'b0;
      nxt_act_char  = {wdata_in[`PCD_BIT_FLAG], wdata_in[`PCD_BIT_ZONE], wdata_in[3:0]};
      // Only a character that is taken lands in the buffer; one sent while busy is dropped.
      nxt_output_char_buffer = wdata_in[6:0];
      if (!par_ok)
      begin
        nxt_pending = 1'b0;
        if (retry_ff)
        begin
          nxt_retry       = 1'b0;
          nxt_err_latched = 1'b0;
          nxt_act_valid   = 1'b1;
          nxt_act_code    = printer_ctl_pkg::ACT_ERR_SYM;
          nxt_state       = printer_ctl_pkg::ST_WAIT;
        end
        else
        begin
          nxt_err_latched = 1'b1;
        end
      end
      else if (err_latched_ff && !exempt)
      begin
        nxt_oerr    = 1'b1;
        nxt_err_irq = 1'b1;
        nxt_pending = 1'b0;
        if (resp_status_ff)
        begin
          nxt_unit_resp = 1'b1;
        end
      end
      else if (pending_ff)
      begin
        nxt_retry     = 1'b0;
        nxt_pending   = 1'b0;
        nxt_act_valid = 1'b1;
        nxt_state     = printer_ctl_pkg::ST_WAIT;
        nxt_act_code  = printer_ctl_pkg::ACT_SPACE;
        if (is_flag)
        begin
          nxt_act_code = printer_ctl_pkg::ACT_SPACE;
        end
        else if (is_rm)
        begin
          nxt_act_valid        = 1'b0;
          nxt_state            = printer_ctl_pkg::ST_IDLE;
          nxt_message_end_flag = 1'b1;
          nxt_alert            = 1'b1;
          nxt_resp_status      = 1'b0;
          nxt_act_code         = act_code_out;
        end
        else if (digit == `PCD_FN_MODE)
        begin
          nxt_act_valid = 1'b0;
          nxt_ms        = 1'b1;
          nxt_alert     = 1'b1;
          nxt_act_code  = act_code_out;
          nxt_state     = printer_ctl_pkg::ST_IDLE;
          if (resp_status_ff)
          begin
            nxt_unit_resp = 1'b1;
            nxt_irq       = 1'b1;
          end
        end
        else if (digit == `PCD_FN_PERIOD)
        begin
          nxt_act_code = printer_ctl_pkg::ACT_PERIOD;
        end
        else if (digit == `PCD_FN_COMMA)
        begin
          nxt_act_code = printer_ctl_pkg::ACT_COMMA;
        end
        else if (digit == `PCD_FN_BLACK)
        begin
          nxt_act_code   = ribbon_red_out ? printer_ctl_pkg::ACT_BLACK : printer_ctl_pkg::ACT_SPACE;
          nxt_ribbon_red = 1'b0;
        end
        else if (digit == `PCD_FN_RED)
        begin
          nxt_act_code   = ribbon_red_out ? printer_ctl_pkg::ACT_SPACE : printer_ctl_pkg::ACT_RED;
          nxt_ribbon_red = 1'b1;
        end
        else if (digit == `PCD_FN_TAB)
        begin
          nxt_act_code = printer_ctl_pkg::ACT_TAB;
        end
        else if (digit == `PCD_FN_SPACE)
        begin
          nxt_act_code = printer_ctl_pkg::ACT_SPACE;
        end
        else if (digit == `PCD_FN_RETURN)
        begin
          nxt_act_code = printer_ctl_pkg::ACT_RETURN;
        end
        else if (digit == `PCD_FN_FEED)
        begin
          nxt_act_code = printer_ctl_pkg::ACT_FEED;
        end
      end
      else if (is_rm && !is_flag)
      begin
        nxt_rm      = 1'b1;
        nxt_alert   = 1'b1;
        nxt_pending = 1'b1;
      end
      else
      begin
        nxt_retry     = 1'b0;
        nxt_act_valid = 1'b1;
        nxt_state     = printer_ctl_pkg::ST_WAIT;
        nxt_act_code  = digit_ok ? printer_ctl_pkg::ACT_PRINT : printer_ctl_pkg::ACT_SPACE;
      end
    end

    if ((state_ff == printer_ctl_pkg::ST_WAIT) && done_rise)
    begin
      nxt_state = printer_ctl_pkg::ST_IDLE;
      if (resp_status_ff)
      begin
        nxt_unit_resp = 1'b1;
        nxt_irq       = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      done_meta_ff <= 1'b0;
      done_sync_ff <= 1'b0;
      done_prev_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      done_meta_ff <= printer_done_in;
      done_sync_ff <= done_meta_ff;
      done_prev_ff <= done_sync_ff;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      state_ff              <= printer_ctl_pkg::ST_IDLE;
      output_char_buffer_ff <= 7'h00;
      unit_addr_ff          <= `PCD_RST_UNIT_ADDR;
      rdata_out             <= '0;
      act_valid_out         <= 1'b0;
      act_code_out          <= printer_ctl_pkg::ACT_NONE;
      act_char_out          <= 6'h00;
      ribbon_red_out        <= `PCD_RST_RIBBON_RED;
      unit_resp_out         <= 1'b0;
      irq_out               <= 1'b0;
      err_irq_out           <= 1'b0;
      rm_ff                 <= 1'b0;
      ms_ff                 <= 1'b0;
      message_end_flag_ff   <= 1'b0;
      alert_ff              <= 1'b0;
      oerr_ff               <= 1'b0;
      pending_ff            <= 1'b0;
      err_latched_ff        <= 1'b0;
      retry_ff              <= 1'b0;
      resp_status_ff        <= `PCD_RST_RESP_STATUS;
    end
    else if (ce_in)
    begin
      state_ff              <= nxt_state;
      output_char_buffer_ff <= nxt_output_char_buffer;
      unit_addr_ff          <= nxt_unit_addr;
      rdata_out             <= nxt_rdata;
      act_valid_out         <= nxt_act_valid;
      act_code_out          <= nxt_act_code;
      act_char_out          <= nxt_act_char;
      ribbon_red_out        <= nxt_ribbon_red;
      unit_resp_out         <= nxt_unit_resp;
      irq_out               <= nxt_irq;
      err_irq_out           <= nxt_err_irq;
      rm_ff                 <= nxt_rm;
      ms_ff                 <= nxt_ms;
      message_end_flag_ff   <= nxt_message_end_flag;
      alert_ff              <= nxt_alert;
      oerr_ff               <= nxt_oerr;
      pending_ff            <= nxt_pending;
      err_latched_ff        <= nxt_err_latched;
      retry_ff              <= nxt_retry;
      resp_status_ff        <= nxt_resp_status;
    end
  end

  property p_rm_seen;
    @(posedge clk_in) disable iff (reset_in)
    (ce_in && char_take && par_ok && !err_latched_ff && !pending_ff && is_rm && !is_flag)
      |=> (rm_ff && alert_ff && pending_ff && !act_valid_out);
  endproperty
  a_rm_seen: assert property (p_rm_seen) else $error("record mark not latched");

  property p_mode_shift;
    @(posedge clk_in) disable iff (reset_in)
    (ce_in && char_take && par_ok && pending_ff && !is_flag && digit == `PCD_FN_MODE)
      |=> (ms_ff && alert_ff && !act_valid_out && !pending_ff);
  endproperty
  a_mode_shift: assert property (p_mode_shift) else $error("mode shift mishandled");

  property p_period;
    @(posedge clk_in) disable iff (reset_in)
    (ce_in && char_take && par_ok && !err_latched_ff && pending_ff && !is_flag && digit == `PCD_FN_PERIOD)
      |=> (act_valid_out && act_code_out == printer_ctl_pkg::ACT_PERIOD);
  endproperty
  a_period: assert property (p_period) else $error("period not issued");

  property p_same_colour;
    @(posedge clk_in) disable iff (reset_in)
    (ce_in && char_take && par_ok && !err_latched_ff && pending_ff && !is_flag && digit == `PCD_FN_BLACK
      && !ribbon_red_out) |=> (act_code_out == printer_ctl_pkg::ACT_SPACE && !ribbon_red_out);
  endproperty
  a_same_colour: assert property (p_same_colour) else $error("same colour shift did not space");

  property p_msg_end;
    @(posedge clk_in) disable iff (reset_in)
    (ce_in && char_take && par_ok && !err_latched_ff && pending_ff && is_rm && !is_flag)
      |=> (message_end_flag_ff && alert_ff && !resp_status_ff) ##1 !irq_out;
  endproperty
  a_msg_end: assert property (p_msg_end) else $error("message end mishandled");

  property p_parity_latch;
    @(posedge clk_in) disable iff (reset_in)
    (ce_in && char_take && !par_ok && !retry_ff) |=> (err_latched_ff && !act_valid_out && !irq_out);
  endproperty
  a_parity_latch: assert property (p_parity_latch) else $error("parity error not latched");

  property p_ignored;
    @(posedge clk_in) disable iff (reset_in)
    (ce_in && char_take && par_ok && err_latched_ff && !exempt)
      |=> (oerr_ff && err_irq_out && !act_valid_out && unit_resp_out == $past(resp_status_ff));
  endproperty
  a_ignored: assert property (p_ignored) else $error("ignored character not flagged");

  property p_test_oerr;
    @(posedge clk_in) disable iff (reset_in)
    (ce_in && rd_in && addr_in == `PCD_OFF_TEST_OERR && oerr_ff)
      |=> (rdata_out[0] && !oerr_ff && !err_latched_ff && retry_ff);
  endproperty
  a_test_oerr: assert property (p_test_oerr) else $error("error test did not clear");

  property p_retry_symbol;
    @(posedge clk_in) disable iff (reset_in)
    (ce_in && char_take && !par_ok && retry_ff)
      |=> (act_valid_out && act_code_out == printer_ctl_pkg::ACT_ERR_SYM && !err_latched_ff && !retry_ff);
  endproperty
  a_retry_symbol: assert property (p_retry_symbol) else $error("error symbol not printed");

  property p_done_resp;
    @(posedge clk_in) disable iff (reset_in)
    (ce_in && state_ff == printer_ctl_pkg::ST_WAIT && done_rise && resp_status_ff)
      |=> (unit_resp_out && irq_out && state_ff == printer_ctl_pkg::ST_IDLE);
  endproperty
  a_done_resp: assert property (p_done_resp) else $error("completion not reported");

endmodule

// ===== rtl/printer_ctl_consts.svh
// Register offsets, character field positions, codes and reset values of the printer control decoder.
// Assumes a plain register port with a 4-bit word address.
`ifndef PRINTER_CTL_CONSTS_SVH
`define PRINTER_CTL_CONSTS_SVH

`define PCD_OFF_CHAR        4'h0
`define PCD_OFF_STATUS      4'h1
`define PCD_OFF_TEST_RM     4'h2
`define PCD_OFF_TEST_MS     4'h3
`define PCD_OFF_TEST_END    4'h4
`define PCD_OFF_TEST_ALERT  4'h5
`define PCD_OFF_TEST_OERR   4'h6
`define PCD_OFF_CTRL        4'h7
`define PCD_OFF_UNIT_ADDR   4'h8

`define PCD_BIT_FLAG        6
`define PCD_BIT_ZONE        5
`define PCD_BIT_CHECK       4

`define PCD_CTRL_ACK        0
`define PCD_CTRL_RESPOND    1

`define PCD_ST_BUSY         0
`define PCD_ST_RM           1
`define PCD_ST_MS           2
`define PCD_ST_END          3
`define PCD_ST_ALERT        4
`define PCD_ST_OERR         5
`define PCD_ST_UNIT_RESP    6
`define PCD_ST_RESP_STATUS  7

`define PCD_RECORD_MARK     4'ha
`define PCD_FN_PERIOD       4'h1
`define PCD_FN_MODE         4'h2
`define PCD_FN_COMMA        4'h3
`define PCD_FN_BLACK        4'h4
`define PCD_FN_RED          4'h5
`define PCD_FN_TAB          4'h6
`define PCD_FN_SPACE        4'h7
`define PCD_FN_RETURN       4'h8
`define PCD_FN_FEED         4'h9
`define PCD_MAX_DIGIT       4'h9

`define PCD_RST_RESP_STATUS 1'b1
`define PCD_RST_UNIT_ADDR   8'h00
`define PCD_RST_RIBBON_RED  1'b0

`endif

// ===== rtl/printer_ctl_pkg.sv
// Types shared by the printer control decoder files.
// Assumes nothing of its surroundings.
package printer_ctl_pkg;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } state_e;

  typedef enum logic [3:0] {
    ACT_NONE    = 4'h0,
    ACT_PRINT   = 4'h1,
    ACT_PERIOD  = 4'h2,
    ACT_COMMA   = 4'h3,
    ACT_BLACK   = 4'h4,
    ACT_RED     = 4'h5,
    ACT_TAB     = 4'h6,
    ACT_SPACE   = 4'h7,
    ACT_RETURN  = 4'h8,
    ACT_FEED    = 4'h9,
    ACT_ERR_SYM = 4'ha
  } action_e;

endpackage

// ===== rtl/char_checker.sv
// Combinational classifier for one incoming seven-bit character from the write data: X O C 8 4 2 1.
// Assumes odd parity over all seven bits, the check bit making the count odd.
`timescale 1ns/100ps
`include "printer_ctl_consts.svh"

module char_checker
(
  input  wire logic [6:0] char_in,
  output logic            parity_ok_out,
  output logic            flag_out,
  output logic            record_mark_out,
  output logic [3:0]      digit_out,
  output logic            valid_digit_out
);

  assign parity_ok_out   = ^char_in;
  assign flag_out        = char_in[`PCD_BIT_FLAG];
  assign digit_out       = char_in[3:0];
  assign record_mark_out = (char_in[3:0] == `PCD_RECORD_MARK) && !char_in[`PCD_BIT_ZONE];
  assign valid_digit_out = (char_in[3:0] <= `PCD_MAX_DIGIT);

endmodule

// ===== verif/printer_model.sv
// Behavioural model of the printer mechanics behind the decoder.
// Assumes the controller's clock; each action pulse is answered by a four-cycle done pulse that rises DELAY-3 cycles later.
`timescale 1ns/100ps

module printer_model
#(
  parameter int DELAY = 12
)
(
  input  wire logic clk_in,
  input  wire logic act_valid_in,
  output logic      done_out
);
  int cnt = 0;

  initial done_out = 1'b0;

  // The done pin rises some cycles after the action starts, stays high four cycles, then falls.
  always @(posedge clk_in)
  begin
    if (act_valid_in)
      cnt <= DELAY;
    else if (cnt > 0)
      cnt <= cnt - 1;
    done_out <= (cnt > 0) && (cnt <= 4);
  end
endmodule

// ===== verif/printer_control_code_decoder_bench.sv
// Self-checking bench for the printer control decoder, driving its register port as the host.
// Assumes the printer model on the action side and the register map of the constants header.
`timescale 1ns/100ps
`include "printer_ctl_consts.svh"

module printer_control_code_decoder_bench;
  logic       clk_in = 1'b0;
  logic       reset_in = 1'b1;
  logic       ce_in = 1'b1;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic       wr_in = 1'b0;
  logic       rd_in = 1'b0;
  logic [7:0] rdata_out;
  logic       done;
  logic       act_valid_out;
  logic [3:0] act_code_out;
  logic [5:0] act_char_out;
  logic       ribbon_red_out;
  logic       unit_resp_out;
  logic       irq_out;
  logic       err_irq_out;
  int         failures = 0;
  int         checks_done = 0;
  bit         hit;
  bit         rib = 1'b0;
  // Rows hold {armed, digit, expected action code}.
  localparam logic [8:0] ROWS [12] = '{9'h031, 9'h112, 9'h133, 9'h147, 9'h155, 9'h157,
                                       9'h144, 9'h166, 9'h177, 9'h188, 9'h199, 9'h0b7};

  printer_control_code_decoder dut (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .printer_done_in(done),
    .act_valid_out(act_valid_out), .act_code_out(act_code_out), .act_char_out(act_char_out),
    .ribbon_red_out(ribbon_red_out), .unit_resp_out(unit_resp_out), .irq_out(irq_out), .err_irq_out(err_irq_out));

  printer_model #(.DELAY(12)) printer (.clk_in(clk_in), .act_valid_in(act_valid_out), .done_out(done));

  initial forever #50 clk_in = ~clk_in;

  // Builds a character with odd parity; bad inverts the check bit.
  function automatic logic [7:0] ch(input logic [3:0] d, input bit bad);
    ch = {3'b000, ~(^d) ^ bad, d};
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    chk(rdata_out, e);
  endtask

  // Watches one interrupt pulse for a bounded span.
  task automatic waitp(input bit e, output bit h);
    h = 1'b0;
    repeat (60)
    begin
      @(negedge clk_in);
      if ((e ? err_irq_out : irq_out) === 1'b1)
        h = 1'b1;
    end
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #600000;
    failures++;
    close_out();
  end

  initial
  begin
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    rd(`PCD_OFF_STATUS, 8'h80);
    rd(`PCD_OFF_UNIT_ADDR, 8'h00);
    rd(4'hf, 8'h00);
    wr(`PCD_OFF_UNIT_ADDR, 8'h42);
    rd(`PCD_OFF_UNIT_ADDR, 8'h42);
    wr(`PCD_OFF_UNIT_ADDR, 8'h4c);
    rd(`PCD_OFF_UNIT_ADDR, 8'h42);
    $display("reset and address test done");
    foreach (ROWS[i])
    begin
      if (ROWS[i][8])
      begin
        wr(`PCD_OFF_CHAR, 8'h1a);
        rd(`PCD_OFF_TEST_RM, 8'h01);
      end
      wr(`PCD_OFF_CHAR, ch(ROWS[i][7:4], 1'b0));
      @(negedge clk_in);
      chk(act_valid_out, 8'h01);
      chk(act_code_out, ROWS[i][3:0]);
      chk(act_char_out, {4'h0, ROWS[i][7:4]});
      if (ROWS[i][3:0] == 4'h5)
        rib = 1'b1;
      if (ROWS[i][3:0] == 4'h4)
        rib = 1'b0;
      chk(ribbon_red_out, rib);
      waitp(1'b0, hit);
      chk(hit, 1'b1);
      chk(unit_resp_out, 1'b1);
    end
    $display("code table test done");
    wr(`PCD_OFF_CHAR, 8'h1a);
    wr(`PCD_OFF_CHAR, ch(4'h2, 1'b0));
    @(negedge clk_in);
    chk(act_valid_out, 8'h00);
    chk(irq_out, 8'h01);
    chk(unit_resp_out, 8'h01);
    rd(`PCD_OFF_TEST_MS, 8'h01);
    rd(`PCD_OFF_TEST_MS, 8'h00);
    rd(`PCD_OFF_TEST_ALERT, 8'h01);
    rd(`PCD_OFF_TEST_ALERT, 8'h00);
    $display("mode shift test done");
    wr(`PCD_OFF_CHAR, ch(4'h3, 1'b1));
    @(negedge clk_in);
    chk(act_valid_out, 8'h00);
    wr(`PCD_OFF_CHAR, 8'h1a);
    rd(`PCD_OFF_TEST_RM, 8'h01);
    wr(`PCD_OFF_CHAR, ch(4'h7, 1'b0));
    waitp(1'b1, hit);
    chk(hit, 1'b1);
    chk(unit_resp_out, 1'b1);
    rd(`PCD_OFF_TEST_OERR, 8'h01);
    rd(`PCD_OFF_TEST_OERR, 8'h00);
    wr(`PCD_OFF_CHAR, ch(4'h3, 1'b1));
    @(negedge clk_in);
    chk(act_code_out, 8'h0a);
    waitp(1'b0, hit);
    chk(hit, 1'b1);
    $display("parity error test done");
    wr(`PCD_OFF_CHAR, 8'h1a);
    wr(`PCD_OFF_CHAR, 8'h1a);
    rd(`PCD_OFF_TEST_END, 8'h01);
    rd(`PCD_OFF_TEST_END, 8'h00);
    wr(`PCD_OFF_CHAR, ch(4'h3, 1'b0));
    @(negedge clk_in);
    chk(act_code_out, 8'h01);
    waitp(1'b0, hit);
    chk(hit, 1'b0);
    $display("message end test done");
    @(posedge clk_in);
    ce_in <= 1'b0;
    wr(`PCD_OFF_CHAR, ch(4'h1, 1'b0));
    ce_in <= 1'b1;
    @(negedge clk_in);
    chk(act_valid_out, 8'h00);
    rd(`PCD_OFF_CHAR, ch(4'h3, 1'b0));
    wr(`PCD_OFF_CTRL, 8'h03);
    wr(`PCD_OFF_CHAR, ch(4'h5, 1'b0));
    wr(`PCD_OFF_CHAR, ch(4'h6, 1'b0));
    rd(`PCD_OFF_CHAR, ch(4'h5, 1'b0));
    waitp(1'b0, hit);
    chk(hit, 1'b1);
    $display("enable and busy test done");
    @(posedge clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    rd(`PCD_OFF_STATUS, 8'h80);
    rd(`PCD_OFF_CHAR, 8'h00);
    $display("mid-run reset test done");
    close_out();
  end
endmodule
